// ### hdl/lpp_map.vh
// Purpose: Register map and constants of the phase/prescale control block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Unlisted bits read as zero
`ifndef LPP_MAP_VH
`define LPP_MAP_VH
`define LPP_OFS_PHASE_PRESCALE 12'h000
`define LPP_OFS_CONTROL        12'h004
`define LPP_OFS_IRQ_STATUS     12'h008
`define LPP_OFS_IRQ_CLEAR      12'h00C
`define LPP_OFS_IRQ_ENABLE     12'h010
`define LPP_OFS_PIXEL_BASE     12'h040
`define LPP_PIXEL_COUNT        12
`define LPP_BIT_WAVEFORM       7
`define LPP_BIT_BIAS           6
`define LPP_BIT_ACTIVE         5
`define LPP_BIT_WALLOW         4
`define LPP_PRESCALE_MSB       3
`define LPP_BIT_ENABLE         0
`define LPP_COMMON_LSB         1
`define LPP_COMMON_MSB         2
`define LPP_IRQ_WRITE_FAIL_ERROR           0
`define LPP_IRQ_FRAME          1
`define LPP_IRQ_WIDTH          2
`define LPP_RST_PHASE_PRESCALE 8'h00
`define LPP_RST_CONTROL        3'h0
`define LPP_RST_IRQ            2'h0
`define LPP_RST_PIXEL          8'h00
`endif

// ### hdl/lpp_phase_prescale.v
// Purpose: Phase/prescale control and status of a segment display driver, with pixel store
// Assumes: APB slave on core_clk; lcd_tick is a one-cycle pulse from the selected clock source
// Notes:   prdata, pready and pslverr come from flops; every access has no extra wait state
//
// How it works
// - Type-B: phase flips only at frame boundaries
// - Type-A: phase flips within each common slot
// - Read-only active status, resets to zero
// - Read-only write-allow status, resets to zero
// - Four-bit prescaler, 1111 divides by sixteen
// - Blocked pixel write sets sticky error flag
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "lpp_map.vh"
`default_nettype none

module lpp_phase_prescale (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Clock source tick
  input  wire        lcd_tick,
  // Drive side
  output reg         frame_tick,
  output reg         drive_phase,
  output reg  [1:0]  common_idx,
  output reg  [1:0]  common_count_sel,
  output reg         bias_mode_sel,
  output reg  [23:0] segment_row,
  output reg         write_fail_error,
  // Interrupt
  output reg         irq
);

  reg        rst_meta_r;
  reg        rst_sync_r;
  reg        waveform_type_sel_r;
  reg        bias_mode_sel_r;
  reg  [3:0] prescaler_sel_r;
  reg        driver_enable_r;
  reg  [1:0] common_count_sel_r;
  reg        driver_active_flag_r;
  reg        write_allow_flag_r;
  reg  [3:0] pre_cnt_r;
  reg  [1:0] com_r;
  reg        half_r;
  reg        phase_r;
  reg  [`LPP_IRQ_WIDTH-1:0] irq_status_r;
  reg  [`LPP_IRQ_WIDTH-1:0] irq_enable_r;
  reg  [7:0] pixel_data_regs [0:`LPP_PIXEL_COUNT-1];
  reg  [31:0] rdata_nxt;
  reg        rd_err_nxt;
  reg  [`LPP_IRQ_WIDTH-1:0] irq_status_nxt;

  localparam [7:0] rst_pp_val  = `LPP_RST_PHASE_PRESCALE;
  localparam [2:0] rst_ctl_val = `LPP_RST_CONTROL;

  wire       setup_ph = psel & ~penable;
  wire       wr_done  = psel & penable & pready & pwrite;
  wire [11:0] pix_ofs = paddr - `LPP_OFS_PIXEL_BASE;
  wire       pix_hit  = (paddr >= `LPP_OFS_PIXEL_BASE) && (pix_ofs[1:0] == 2'h0) &&
                        (pix_ofs[11:2] < `LPP_PIXEL_COUNT);
  wire [3:0] pix_idx  = pix_ofs[5:2];
  wire       pix_wr   = wr_done & pix_hit;
  wire       pre_wrap = lcd_tick & (pre_cnt_r == prescaler_sel_r);
  // Greater-or-equal also wraps a slot index left above a newly lowered count
  wire       com_last = (com_r >= common_count_sel_r);
  // Type-A spends two ticks in each common slot, type-B one
  wire       slot_end = waveform_type_sel_r ? 1'b1 : half_r;
  wire       frame_end = driver_active_flag_r & pre_wrap & slot_end & com_last;

  // Reset release through two flops
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Software registers
  always @(posedge core_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      waveform_type_sel_r <= rst_pp_val[`LPP_BIT_WAVEFORM];
      bias_mode_sel_r     <= 1'b0;
      prescaler_sel_r     <= 4'h0;
      driver_enable_r     <= 1'b0;
      common_count_sel_r  <= 2'h0;
      irq_enable_r        <= `LPP_RST_IRQ;
    end
    else if (wr_done)
    begin
      case (paddr)
        `LPP_OFS_PHASE_PRESCALE:
        begin
          waveform_type_sel_r <= pwdata[`LPP_BIT_WAVEFORM];
          bias_mode_sel_r     <= pwdata[`LPP_BIT_BIAS];
          prescaler_sel_r     <= pwdata[`LPP_PRESCALE_MSB:0];
        end
        `LPP_OFS_CONTROL:
        begin
          driver_enable_r    <= pwdata[`LPP_BIT_ENABLE];
          common_count_sel_r <= pwdata[`LPP_COMMON_MSB:`LPP_COMMON_LSB];
        end
        `LPP_OFS_IRQ_ENABLE:
          irq_enable_r <= pwdata[`LPP_IRQ_WIDTH-1:0];
        default:
          irq_enable_r <= irq_enable_r;
      endcase
    end
  end

  // Pixel store; a write while writes are not allowed is dropped
  integer i;
  always @(posedge core_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      for (i = 0; i < `LPP_PIXEL_COUNT; i = i + 1)
        pixel_data_regs[i] <= `LPP_RST_PIXEL;
    end
    else if (pix_wr && write_allow_flag_r)
    begin
      pixel_data_regs[pix_idx] <= pwdata[7:0];
    end
  end

  // Prescaler and phase sequencer
  always @(posedge core_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      pre_cnt_r            <= 4'h0;
      com_r                <= 2'h0;
      half_r               <= 1'b0;
      phase_r              <= 1'b0;
      driver_active_flag_r <= 1'b0;
      write_allow_flag_r   <= 1'b0;
    end
    else
    begin
      // Division ratio is prescaler_sel + 1
      if (!driver_active_flag_r || pre_wrap)
        pre_cnt_r <= 4'h0;
      else if (lcd_tick)
        pre_cnt_r <= pre_cnt_r + 4'h1;
      if (!driver_active_flag_r)
      begin
        com_r   <= 2'h0;
        half_r  <= 1'b0;
        phase_r <= 1'b0;
      end
      else if (pre_wrap)
      begin
        if (waveform_type_sel_r)
        begin
          half_r <= 1'b0;
          if (com_last)
            phase_r <= ~phase_r;
        end
        else
        begin
          half_r  <= ~half_r;
          phase_r <= ~phase_r;
        end
        if (slot_end)
          com_r <= com_last ? 2'h0 : com_r + 2'h1;
      end
      // Start at once, stop only at a frame boundary so the glass sees no DC
      if (driver_enable_r)
        driver_active_flag_r <= 1'b1;
      else if (frame_end || !driver_active_flag_r)
        driver_active_flag_r <= 1'b0;
      // Writes are held off in the cycle after the sequencer steps
      write_allow_flag_r <= ~(driver_active_flag_r & lcd_tick &
                              (pre_cnt_r == prescaler_sel_r));
    end
  end

  // Sticky events: set wins over a clear in the same cycle
  always @*
  begin
    irq_status_nxt = irq_status_r;
    if (wr_done && paddr == `LPP_OFS_IRQ_CLEAR)
      irq_status_nxt = irq_status_r & ~pwdata[`LPP_IRQ_WIDTH-1:0];
    if (pix_wr && !write_allow_flag_r)
      irq_status_nxt[`LPP_IRQ_WRITE_FAIL_ERROR] = 1'b1;
    if (frame_end)
      irq_status_nxt[`LPP_IRQ_FRAME] = 1'b1;
  end

  always @(posedge core_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      irq_status_r <= `LPP_RST_IRQ;
    else
      irq_status_r <= irq_status_nxt;
  end

  // Read mux
  always @*
  begin
    rdata_nxt  = 32'h0000_0000;
    rd_err_nxt = 1'b0;
    case (paddr)
      `LPP_OFS_PHASE_PRESCALE:
        rdata_nxt[7:0] = {waveform_type_sel_r, bias_mode_sel_r, driver_active_flag_r,
                          write_allow_flag_r, prescaler_sel_r};
      `LPP_OFS_CONTROL:
        rdata_nxt[2:0] = {common_count_sel_r, driver_enable_r};
      `LPP_OFS_IRQ_STATUS:
        rdata_nxt[`LPP_IRQ_WIDTH-1:0] = irq_status_r;
      `LPP_OFS_IRQ_CLEAR:
        rdata_nxt = 32'h0000_0000;
      `LPP_OFS_IRQ_ENABLE:
        rdata_nxt[`LPP_IRQ_WIDTH-1:0] = irq_enable_r;
      default:
      begin
        if (pix_hit)
          rdata_nxt[7:0] = pixel_data_regs[pix_idx];
        else
          rd_err_nxt = 1'b1;
      end
    endcase
  end

  // APB answer: ready in the first access cycle
  always @(posedge core_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph & rd_err_nxt;
      if (setup_ph && !pwrite)
        prdata <= rdata_nxt;
    end
  end

  // Drive-side outputs
  always @(posedge core_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      frame_tick       <= 1'b0;
      drive_phase      <= 1'b0;
      common_idx       <= 2'h0;
      common_count_sel <= rst_ctl_val[`LPP_COMMON_MSB:`LPP_COMMON_LSB];
      bias_mode_sel    <= 1'b0;
      segment_row      <= 24'h00_0000;
      write_fail_error <= 1'b0;
      irq              <= 1'b0;
    end
    else
    begin
      frame_tick       <= driver_active_flag_r & pre_wrap;
      drive_phase      <= phase_r;
      common_idx       <= com_r;
      common_count_sel <= common_count_sel_r;
      bias_mode_sel    <= bias_mode_sel_r;
      segment_row      <= {pixel_data_regs[{com_r, 1'b0} + com_r + 4'h2],
                           pixel_data_regs[{com_r, 1'b0} + com_r + 4'h1],
                           pixel_data_regs[{com_r, 1'b0} + com_r]};
      write_fail_error <= irq_status_nxt[`LPP_IRQ_WRITE_FAIL_ERROR];
      irq              <= |(irq_status_nxt & irq_enable_r);
    end
  end

endmodule

`default_nettype wire

// ### dv/lpp_phase_prescale_assertions.sv
// Purpose: Port-level checks of the phase/prescale block
// Assumes: One clock domain; waveform type tracked from APB writes
// Notes:   Mode changes are only checked as software performs them
`timescale 1ns/10ps
`default_nettype none
module lpp_phase_prescale_assertions (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        lcd_tick,
  input wire logic        frame_tick,
  input wire logic        drive_phase,
  input wire logic [1:0]  common_idx,
  input wire logic        write_fail_error,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire  acc_wr = psel && penable && pready && pwrite;
  logic wft_r;
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
      wft_r <= 1'b0;
    else if (acc_wr && paddr == 12'h000)
      wft_r <= pwdata[7];
  property p_type_b;
    wft_r && $changed(drive_phase) |-> $past(frame_tick) && common_idx == 2'h0;
  endproperty
  a_type_b: assert property (p_type_b) else $error("phase moved off a frame boundary");
  property p_type_a;
    !wft_r && $changed(common_idx) |-> $changed(drive_phase);
  endproperty
  a_type_a: assert property (p_type_a) else $error("phase held across a common step");
  property p_frame;
    frame_tick |-> $past(lcd_tick);
  endproperty
  a_frame: assert property (p_frame) else $error("frame tick without a source tick");
  property p_write_fail_error_hold;
    write_fail_error && !(acc_wr && paddr == 12'h00C && pwdata[0]) |=> write_fail_error;
  endproperty
  a_write_fail_error_hold: assert property (p_write_fail_error_hold) else $error("error flag dropped uncleared");
  property p_write_fail_error_set;
    $rose(write_fail_error) |-> $past(acc_wr && paddr[11:6] == 6'h01);
  endproperty
  a_write_fail_error_set: assert property (p_write_fail_error_set) else $error("error flag without pixel write");
  property p_ready;
    pready |-> psel && penable && $past(psel && !penable) && !$past(pready);
  endproperty
  a_ready: assert property (p_ready) else $error("pready outside first access cycle");
  c_frame: cover property (frame_tick);
  c_write_fail_error: cover property ($rose(write_fail_error));
  c_irq: cover property (irq);
endmodule
bind lpp_phase_prescale lpp_phase_prescale_assertions u_chk (.core_clk, .rstn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .lcd_tick, .frame_tick, .drive_phase, .common_idx, .write_fail_error, .irq);
`default_nettype wire

// ### dv/lcd_phase_prescale_control_test.sv
// Purpose: Register and drive-sequence tests of the phase/prescale block
// Assumes: APB with no wait states expected but waited for
// Notes:   A source tick is launched with a pixel write to hit the step cycle
`timescale 1ns/10ps
`default_nettype none
module lcd_phase_prescale_control_test;
  logic        core_clk, rstn, psel, penable, pwrite, lcd_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, frame_tick, drive_phase, bias_mode_sel, write_fail_error, irq, ph_q;
  logic [1:0]  common_idx, common_count_sel;
  logic [23:0] segment_row;
  integer      err_total, tests_run, fcnt, pcnt, f0, p0;
  lpp_phase_prescale u_dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .lcd_tick, .frame_tick, .drive_phase, .common_idx, .common_count_sel, .bias_mode_sel,
    .segment_row, .write_fail_error, .irq);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    fcnt <= fcnt + (frame_tick === 1'b1);
    pcnt <= pcnt + (drive_phase !== ph_q);
    ph_q <= drive_phase;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic tk);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    lcd_tick <= tk;
    @(posedge core_clk);
    penable <= 1'b1;
    lcd_tick <= 1'b0;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic ticks(input integer n);
    repeat (n)
    begin
      @(posedge core_clk);
      lcd_tick <= 1'b1;
      @(posedge core_clk);
      lcd_tick <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
  endtask
  task complete_run;
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {rstn, psel, penable, pwrite, lcd_tick, ph_q} = 6'h00;
    {paddr, pwdata} = 44'h0;
    {err_total, tests_run, fcnt, pcnt} = 128'h0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(0, 12'h000, 32'h0, 0);
    chk(rd, 32'h10);
    apb(1, 12'h000, 32'hBF, 0);
    apb(0, 12'h000, 32'h0, 0);
    chk(rd, 32'h9F);
    apb(1, 12'h004, 32'h7, 0);
    apb(0, 12'h000, 32'h0, 0);
    chk(rd, 32'hBF);
    f0 = fcnt;
    p0 = pcnt;
    ticks(64);
    chk(fcnt - f0, 32'h4);
    chk(pcnt - p0, 32'h1);
    apb(1, 12'h000, 32'h0F, 0);
    f0 = fcnt;
    p0 = pcnt;
    ticks(32);
    chk(pcnt - p0, 32'h2);
    chk(fcnt - f0, 32'h2);
    chk({30'h0, common_idx}, 32'h1);
    apb(1, 12'h040, 32'hA5, 0);
    apb(0, 12'h040, 32'h0, 0);
    chk(rd, 32'hA5);
    apb(1, 12'h04C, 32'h3C, 0);
    repeat (2) @(posedge core_clk);
    chk({8'h0, segment_row}, 32'h3C);
    apb(1, 12'h000, 32'h00, 0);
    apb(1, 12'h044, 32'h5A, 1);
    repeat (10) @(posedge core_clk);
    chk({31'h0, write_fail_error}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(0, 12'h044, 32'h0, 0);
    chk(rd, 32'h0);
    apb(1, 12'h010, 32'h1, 0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1, 12'h00C, 32'h1, 0);
    repeat (2) @(posedge core_clk);
    chk({30'h0, irq, write_fail_error}, 32'h0);
    apb(0, 12'hFFC, 32'h0, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1, 12'h004, 32'h3, 0);
    apb(1, 12'h000, 32'h40, 0);
    repeat (2) @(posedge core_clk);
    chk({29'h0, bias_mode_sel, common_count_sel}, 32'h5);
    complete_run;
  end
  initial
  begin
    #100000;
    err_total++;
    complete_run;
  end
endmodule
`default_nettype wire
